// ==== inc/qfc_pkg.sv ====
package qfc_pkg;

   // Register byte addresses
   localparam logic [31:0] ADDR_CTRL_BUS = 32'h0C00_0000;
   localparam logic [31:0] ADDR_CTRL_MODE = 32'h0C00_0004;
   localparam logic [31:0] ADDR_RECV = 32'h0C00_0008;
   localparam logic [31:0] ADDR_STATUS = 32'h0C00_0014;
   localparam logic [31:0] ADDR_WRITE_DATA = 32'h0C00_0018;
   localparam logic [31:0] ADDR_READ_DATA = 32'h0C00_001C;
   localparam logic [31:0] ADDR_DUMMY_DATA = 32'h0C00_0020;
   localparam logic [31:0] ADDR_ERASE = 32'h0C00_0024;

   // Mode register fields
   localparam int B_AUTO = 0;
   localparam int B_CLK = 1;
   localparam int B_IO2_OEN = 2;
   localparam int B_IO3_OEN = 3;
   localparam int B_IO2_DAT = 4;
   localparam int B_IO3_DAT = 5;
   localparam int B_NWS = 6;
   localparam int B_USE32 = 13;
   localparam logic [31:0] CTRL_MODE_MASK = 32'h0000_207F;
   localparam logic [31:0] CTRL_MODE_RST = 32'h0000_0000;
   localparam logic [31:0] RECV_RST = 32'h0000_0000;

   // Bus control and erase fields
   localparam int B_CS_EN = 0;
   localparam int B_CS_DIS = 1;
   localparam int B_ERASE = 0;

   // Bytes on the serial link
   localparam logic [7:0] READ_CMD = 8'h03;
   localparam logic [7:0] DUMMY_BYTE = 8'hFF;
   localparam logic [7:0] FILL_BYTE = 8'h00;
   localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
   localparam logic [2:0] ADDR_BYTES_4 = 3'h4;
   localparam logic [2:0] DATA_BYTES = 3'h4;
   localparam logic [3:0] LAST_HALF = 4'hF;

   // Serial clock timing
   localparam int SYS_CLK_NS = 100;
   localparam int SCK_HALF_NS = 400;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_MAN = 3'b001,
      ST_CMD = 3'b010,
      ST_ADDR = 3'b011,
      ST_DATA = 3'b100
   } qfc_state_t;

   typedef enum logic [1:0] {
      OP_WRITE = 2'b00,
      OP_READ = 2'b01,
      OP_DUMMY = 2'b10,
      OP_AUTO = 2'b11
   } qfc_op_t;

endpackage : qfc_pkg

// ==== rtl/qfc_shift.sv ====
`timescale 1ns/100ps
module qfc_shift #(
   parameter int HALF_CYC = qfc_pkg::SCK_HALF_CYC
) (
   input wire logic sys_clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic start, // Pulse: send one byte
   input wire logic [7:0] tx_byte, // Byte to send
   input wire logic cpol, // Idle clock level
   input wire logic miso, // Synchronised input line
   output logic sck, // Serial clock
   output logic mosi, // Serial data out
   output logic done, // Pulse: byte finished
   output logic [7:0] rx_byte // Byte received
);
   import qfc_pkg::*;

   logic [7:0] div_ff, nxt_div;
   logic [3:0] cnt_ff, nxt_cnt;
   logic act_ff, nxt_act;
   logic sck_ff, nxt_sck;
   logic smp_ff, nxt_smp;
   logic done_ff, nxt_done;
   logic [7:0] tx_ff, nxt_tx;
   logic [7:0] rx_ff, nxt_rx;
   logic tick;

   // Sixteen clock halves per byte; sample on rising, shift on falling
   always_comb begin
      nxt_div = div_ff;
      nxt_cnt = cnt_ff;
      nxt_act = act_ff;
      nxt_sck = sck_ff;
      nxt_smp = smp_ff;
      nxt_tx = tx_ff;
      nxt_rx = rx_ff;
      nxt_done = 1'b0;
      tick = act_ff && (div_ff == 8'(HALF_CYC - 1));
      if (!act_ff) begin
         nxt_sck = cpol; // RULE_09 RULE_10
         nxt_div = 8'h00;
         if (start) begin
            nxt_act = 1'b1;
            nxt_tx = tx_byte;
            nxt_cnt = 4'h0;
            nxt_smp = 1'b0;
         end
      end else begin
         nxt_div = tick ? 8'h00 : 8'(div_ff + 8'h01);
         if (tick) begin
            nxt_sck = !sck_ff;
            nxt_cnt = 4'(cnt_ff + 4'h1);
            if (!sck_ff) begin
               nxt_rx = {rx_ff[6:0], miso};
               nxt_smp = 1'b1;
            end else if (smp_ff) begin
               // Mode 3 opens on a falling edge that must not shift
               nxt_tx = {tx_ff[6:0], 1'b0};
            end
            if (cnt_ff == LAST_HALF) begin
               nxt_act = 1'b0;
               nxt_done = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_ff <= 8'h00;
         cnt_ff <= 4'h0;
         act_ff <= 1'b0;
         sck_ff <= 1'b0;
         smp_ff <= 1'b0;
         done_ff <= 1'b0;
         tx_ff <= 8'h00;
         rx_ff <= 8'h00;
      end else begin
         div_ff <= nxt_div;
         cnt_ff <= nxt_cnt;
         act_ff <= nxt_act;
         sck_ff <= nxt_sck;
         smp_ff <= nxt_smp;
         done_ff <= nxt_done;
         tx_ff <= nxt_tx;
         rx_ff <= nxt_rx;
      end
   end

   assign sck = sck_ff;
   assign mosi = tx_ff[7];
   assign done = done_ff;
   assign rx_byte = rx_ff;

endmodule : qfc_shift

// ==== rtl/qfc_ctrl.sv ====
`timescale 1ns/100ps
// Operation
// RULE_01: Wait-state select 0 stretches data-port accesses with hready until done.
// RULE_02: Wait-state select 1 completes data-port accesses without hready waits.
// RULE_03: Without waits, software polls the busy flag for completion.
// RULE_04: Select bit matters only in manual mode; auto mode always waits.
// RULE_05: IO3 enable 1 drives IO3 pad with IO3 value; 0 makes input.
// RULE_06: IO2 enable 1 drives IO2 pad with IO2 value; 0 makes input.
// RULE_07: Software uses IO3 enable only single/dual, clears it for quad auto.
// RULE_08: Software uses IO2 enable only single/dual, clears it for quad auto.
// RULE_09: Clock mode 0 gives SPI mode 0, clock low while deselected.
// RULE_10: Clock mode 1 gives SPI mode 3, clock high while deselected.
// RULE_11: Mode bit 0 manual, 1 auto; mode bits reset to zero.
// RULE_12: During erase the operating mode bit ignores writes.
// RULE_13: Receive register holds bytes fetched by manual read-port accesses.
// RULE_14: Auto mode sends three address bytes, or four when selected.
// RULE_15: IO2/IO3 register settings reach the pads within cycles, no transfer.
module qfc_ctrl #(
   parameter int SCK_HALF = qfc_pkg::SCK_HALF_CYC
) (
   input wire logic sys_clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic hsel_reg, // Register space select
   input wire logic hsel_flash, // Flash space select
   input wire logic [31:0] haddr, // Bus address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready_in, // Bus ready in
   output logic [31:0] hrdata, // Read data
   output logic hready, // Ready out
   output logic cs_n, // Chip select
   output logic sck, // Serial clock
   output logic io0_o, // Serial data out
   input wire logic io1_i, // Serial data in
   input wire logic io2_i, // Pad 2 in
   output logic io2_o, // Pad 2 out
   output logic io2_oe, // Pad 2 enable
   input wire logic io3_i, // Pad 3 in
   output logic io3_o, // Pad 3 out
   output logic io3_oe // Pad 3 enable
);
   import qfc_pkg::*;

   logic [2:0] pad_s1_ff, pad_s2_ff;
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [31:0] recv_ff, nxt_recv;
   logic [31:0] hrdata_ff, nxt_hrdata;
   logic [31:0] addr_sh_ff, nxt_addr_sh;
   logic [31:0] data_ff, nxt_data;
   logic [31:0] ph_addr_ff, nxt_ph_addr;
   logic erase_ff, nxt_erase;
   logic hready_ff, nxt_hready;
   logic cs_n_ff, nxt_cs_n;
   logic busy_ff, nxt_busy;
   logic wait_ff, nxt_wait;
   logic ph_valid_ff, nxt_ph_valid;
   logic ph_write_ff, nxt_ph_write;
   logic ph_flash_ff, nxt_ph_flash;
   logic ph_run_ff, nxt_ph_run;
   logic start_ff, nxt_start;
   logic [7:0] tx_ff, nxt_tx;
   logic [2:0] cnt_ff, nxt_cnt;
   logic [3:0] pad_ff, nxt_pad;
   qfc_state_t state_ff, nxt_state;
   qfc_op_t op_ff, nxt_op;
   logic addr_ok, auto_md, eng_done;
   logic [7:0] rx_byte;

   // True for the three manual data ports
   function automatic logic is_port(input logic [31:0] a);
      is_port = (a == ADDR_WRITE_DATA) || (a == ADDR_READ_DATA) || (a == ADDR_DUMMY_DATA);
   endfunction : is_port

   // Input pads come from outside; two flops before use
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pad_s1_ff <= 3'h0;
         pad_s2_ff <= 3'h0;
      end else begin
         pad_s1_ff <= {io3_i, io2_i, io1_i};
         pad_s2_ff <= pad_s1_ff;
      end
   end

   qfc_shift #(
      .HALF_CYC(SCK_HALF)
   ) u_shift (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(start_ff),
      .tx_byte(tx_ff),
      .cpol(ctrl_ff[B_CLK]),
      .miso(pad_s2_ff[0]),
      .sck(sck),
      .mosi(io0_o),
      .done(eng_done),
      .rx_byte(rx_byte)
   );

   // Bus slave, registers and transfer sequencer
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_recv = recv_ff;
      nxt_hrdata = hrdata_ff;
      nxt_addr_sh = addr_sh_ff;
      nxt_data = data_ff;
      nxt_ph_addr = ph_addr_ff;
      nxt_erase = erase_ff;
      nxt_hready = hready_ff;
      nxt_cs_n = cs_n_ff;
      nxt_busy = busy_ff;
      nxt_wait = wait_ff;
      nxt_ph_write = ph_write_ff;
      nxt_ph_flash = ph_flash_ff;
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_tx = tx_ff;
      nxt_cnt = cnt_ff;
      nxt_start = 1'b0;
      nxt_ph_valid = 1'b0;
      nxt_ph_run = 1'b0;
      auto_md = ctrl_ff[B_AUTO]; // RULE_11
      addr_ok = hready_in && hready_ff && htrans[1] && (hsel_reg || hsel_flash);
      // Pads follow the register one cycle later
      nxt_pad = {ctrl_ff[B_IO3_OEN], ctrl_ff[B_IO3_DAT], ctrl_ff[B_IO2_OEN], ctrl_ff[B_IO2_DAT]}; // RULE_15

      // Data phase of a register write
      if (ph_valid_ff && ph_write_ff && !ph_flash_ff) begin
         case (ph_addr_ff)
            ADDR_CTRL_MODE: begin
               nxt_ctrl = hwdata & CTRL_MODE_MASK;
               if (erase_ff) begin
                  nxt_ctrl[B_AUTO] = ctrl_ff[B_AUTO]; // RULE_12
               end
            end
            ADDR_CTRL_BUS: begin
               if (!auto_md && hwdata[B_CS_EN]) begin
                  nxt_cs_n = 1'b0;
               end
               if (!auto_md && hwdata[B_CS_DIS]) begin
                  nxt_cs_n = 1'b1;
               end
            end
            ADDR_ERASE: begin
               nxt_erase = hwdata[B_ERASE];
            end
            default: begin
            end
         endcase
      end

      // Data phase of an accepted transfer launches the first byte
      if (ph_run_ff) begin
         nxt_start = 1'b1;
         case (op_ff)
            OP_WRITE: begin
               nxt_state = ST_MAN;
               nxt_tx = hwdata[7:0];
            end
            OP_READ: begin
               nxt_state = ST_MAN;
               nxt_tx = FILL_BYTE;
            end
            OP_DUMMY: begin
               nxt_state = ST_MAN;
               nxt_tx = DUMMY_BYTE;
            end
            default: begin
               nxt_state = ST_CMD;
               nxt_tx = READ_CMD;
               nxt_cs_n = 1'b0;
            end
         endcase
      end

      // Byte completions
      case (state_ff)
         ST_MAN: begin
            if (eng_done) begin
               nxt_state = ST_IDLE;
               nxt_busy = 1'b0; // RULE_03
               nxt_hready = 1'b1; // RULE_01
               if (op_ff == OP_READ) begin
                  nxt_recv = {recv_ff[23:0], rx_byte}; // RULE_13
                  if (wait_ff) begin
                     nxt_hrdata = {recv_ff[23:0], rx_byte};
                  end
               end
            end
         end
         ST_CMD: begin
            if (eng_done) begin
               nxt_state = ST_ADDR;
               nxt_cnt = ctrl_ff[B_USE32] ? ADDR_BYTES_4 : ADDR_BYTES_3; // RULE_14
               nxt_start = 1'b1;
               nxt_tx = addr_sh_ff[31:24];
               nxt_addr_sh = {addr_sh_ff[23:0], 8'h00};
            end
         end
         ST_ADDR: begin
            if (eng_done) begin
               nxt_start = 1'b1;
               if (cnt_ff == 3'h1) begin
                  nxt_state = ST_DATA;
                  nxt_cnt = DATA_BYTES;
                  nxt_tx = FILL_BYTE;
               end else begin
                  nxt_cnt = 3'(cnt_ff - 3'h1);
                  nxt_tx = addr_sh_ff[31:24];
                  nxt_addr_sh = {addr_sh_ff[23:0], 8'h00};
               end
            end
         end
         ST_DATA: begin
            if (eng_done) begin
               // First byte from flash lands in the low lane
               nxt_data = {rx_byte, data_ff[31:8]};
               if (cnt_ff == 3'h1) begin
                  nxt_state = ST_IDLE;
                  nxt_cs_n = 1'b1;
                  nxt_busy = 1'b0;
                  nxt_hready = 1'b1; // RULE_04
                  nxt_hrdata = {rx_byte, data_ff[31:8]};
               end else begin
                  nxt_cnt = 3'(cnt_ff - 3'h1);
                  nxt_start = 1'b1;
                  nxt_tx = FILL_BYTE;
               end
            end
         end
         default: begin
         end
      endcase

      // Address phase
      if (addr_ok) begin
         nxt_ph_valid = 1'b1;
         nxt_ph_write = hwrite;
         nxt_ph_addr = haddr;
         nxt_ph_flash = hsel_flash;
         if (hsel_reg && !hwrite) begin
            case (haddr)
               ADDR_CTRL_MODE: nxt_hrdata = ctrl_ff;
               ADDR_RECV, ADDR_READ_DATA: nxt_hrdata = recv_ff;
               ADDR_STATUS: nxt_hrdata = {29'h0, pad_s2_ff[2:1], busy_ff};
               ADDR_ERASE: nxt_hrdata = {31'h0, erase_ff};
               default: nxt_hrdata = 32'h0000_0000;
            endcase
         end
         // A busy controller ignores further port accesses
         if (hsel_reg && is_port(haddr) && !busy_ff) begin
            nxt_ph_run = 1'b1;
            nxt_busy = 1'b1;
            nxt_op = (haddr == ADDR_WRITE_DATA) ? OP_WRITE : (haddr == ADDR_READ_DATA) ? OP_READ : OP_DUMMY;
            nxt_wait = auto_md || !ctrl_ff[B_NWS]; // RULE_04
            if (auto_md || !ctrl_ff[B_NWS]) begin
               nxt_hready = 1'b0; // RULE_01 RULE_02
            end
         end
         if (hsel_flash && !hwrite) begin
            nxt_hrdata = 32'h0000_0000;
            if (auto_md && !busy_ff) begin
               nxt_ph_run = 1'b1;
               nxt_busy = 1'b1;
               nxt_op = OP_AUTO;
               nxt_wait = 1'b1;
               nxt_hready = 1'b0; // RULE_04
               nxt_addr_sh = ctrl_ff[B_USE32] ? haddr : {haddr[23:0], 8'h00}; // RULE_14
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_ff <= CTRL_MODE_RST; // RULE_11
         recv_ff <= RECV_RST;
         hrdata_ff <= 32'h0000_0000;
         addr_sh_ff <= 32'h0000_0000;
         data_ff <= 32'h0000_0000;
         ph_addr_ff <= 32'h0000_0000;
         erase_ff <= 1'b0;
         hready_ff <= 1'b1;
         cs_n_ff <= 1'b1;
         busy_ff <= 1'b0;
         wait_ff <= 1'b0;
         ph_valid_ff <= 1'b0;
         ph_write_ff <= 1'b0;
         ph_flash_ff <= 1'b0;
         ph_run_ff <= 1'b0;
         start_ff <= 1'b0;
         tx_ff <= 8'h00;
         cnt_ff <= 3'h0;
         pad_ff <= 4'h0;
         state_ff <= ST_IDLE;
         op_ff <= OP_WRITE;
      end else begin
         ctrl_ff <= nxt_ctrl;
         recv_ff <= nxt_recv;
         hrdata_ff <= nxt_hrdata;
         addr_sh_ff <= nxt_addr_sh;
         data_ff <= nxt_data;
         ph_addr_ff <= nxt_ph_addr;
         erase_ff <= nxt_erase;
         hready_ff <= nxt_hready;
         cs_n_ff <= nxt_cs_n;
         busy_ff <= nxt_busy;
         wait_ff <= nxt_wait;
         ph_valid_ff <= nxt_ph_valid;
         ph_write_ff <= nxt_ph_write;
         ph_flash_ff <= nxt_ph_flash;
         ph_run_ff <= nxt_ph_run;
         start_ff <= nxt_start;
         tx_ff <= nxt_tx;
         cnt_ff <= nxt_cnt;
         pad_ff <= nxt_pad;
         state_ff <= nxt_state;
         op_ff <= nxt_op;
      end
   end

   assign hrdata = hrdata_ff;
   assign hready = hready_ff;
   assign cs_n = cs_n_ff;
   assign io2_o = pad_ff[0]; // RULE_06
   assign io2_oe = pad_ff[1];
   assign io3_o = pad_ff[2]; // RULE_05
   assign io3_oe = pad_ff[3];

   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_port_acc;
      addr_ok && hsel_reg && is_port(haddr) && !busy_ff && !ctrl_ff[B_AUTO];
   endsequence
   sequence s_auto_start;
      addr_ok && hsel_flash && !hwrite && ctrl_ff[B_AUTO] && !busy_ff;
   endsequence

   property p_man_wait;
      s_port_acc ##0 !ctrl_ff[B_NWS] |=> !hready_ff [*8];
   endproperty
   a_man_wait: assert property (p_man_wait) else $error("manual access did not wait"); // RULE_01
   property p_man_nowait;
      s_port_acc ##0 ctrl_ff[B_NWS] |=> hready_ff [*8];
   endproperty
   a_man_nowait: assert property (p_man_nowait) else $error("manual access waited"); // RULE_02
   property p_auto_wait;
      s_auto_start |=> !hready_ff [*8] ##[1:1000] hready_ff;
   endproperty
   a_auto_wait: assert property (p_auto_wait) else $error("auto read wait wrong"); // RULE_04
   property p_io3;
      $rose(ctrl_ff[B_IO3_OEN]) |=> io3_oe && (io3_o == $past(ctrl_ff[B_IO3_DAT]));
   endproperty
   a_io3: assert property (p_io3) else $error("io3 pad not driven"); // RULE_05
   property p_io2;
      $fell(ctrl_ff[B_IO2_OEN]) |=> !io2_oe;
   endproperty
   a_io2: assert property (p_io2) else $error("io2 pad still driven"); // RULE_06
   property p_mode0;
      cs_n && (state_ff == ST_IDLE) && ($past(state_ff) == ST_IDLE) && !ctrl_ff[B_CLK] && $stable(ctrl_ff[B_CLK])
         && !start_ff |-> !sck;
   endproperty
   a_mode0: assert property (p_mode0) else $error("clock not low in mode 0"); // RULE_09
   property p_mode3;
      cs_n && (state_ff == ST_IDLE) && ($past(state_ff) == ST_IDLE) && ctrl_ff[B_CLK] && $stable(ctrl_ff[B_CLK])
         && !start_ff |-> sck;
   endproperty
   a_mode3: assert property (p_mode3) else $error("clock not high in mode 3"); // RULE_10
   property p_reset;
      @(posedge sys_clk) disable iff (1'b0) rst |=> (ctrl_ff == CTRL_MODE_RST) && hready_ff && cs_n_ff;
   endproperty
   a_reset: assert property (p_reset) else $error("mode bits not cleared by reset"); // RULE_11
   property p_erase_lock;
      ph_valid_ff && ph_write_ff && !ph_flash_ff && (ph_addr_ff == ADDR_CTRL_MODE) && erase_ff
         |=> $stable(ctrl_ff[B_AUTO]);
   endproperty
   a_erase_lock: assert property (p_erase_lock) else $error("mode bit changed during erase"); // RULE_12
   property p_recv;
      (state_ff == ST_MAN) && eng_done && (op_ff == OP_READ) |=> recv_ff == {$past(recv_ff[23:0]), $past(rx_byte)};
   endproperty
   a_recv: assert property (p_recv) else $error("receive word not updated"); // RULE_13
   property p_addr_len;
      (state_ff == ST_CMD) && eng_done |=> cnt_ff == (ctrl_ff[B_USE32] ? ADDR_BYTES_4 : ADDR_BYTES_3);
   endproperty
   a_addr_len: assert property (p_addr_len) else $error("wrong address length"); // RULE_14

endmodule : qfc_ctrl

// ==== verif/qfc_flash_model.sv ====
`timescale 1ns/100ps
// Serial flash stand-in: byte k of each session is 3C + 11*k
module qfc_flash_model (
   input wire logic cs_n, // Select, low
   input wire logic sck, // Serial clock
   input wire logic mosi, // Data in
   output logic miso, // Data out
   output logic [7:0] rx_byte, // Last byte in
   output logic [7:0] rx_count // Bytes this session
);
   logic [7:0] in_sr = 8'h00;
   logic [7:0] out_sr = 8'h00;
   logic idle_v = 1'h0;
   logic moved = 1'h0;
   int bitn = 0;
   initial rx_byte = 8'h00;
   initial rx_count = 8'h00;
   // First bit stands before the first rising edge
   always @(negedge cs_n) begin
      bitn = 0;
      rx_count = 8'h00;
      moved = 1'h0;
      out_sr = 8'h3C;
   end
   // Sampled on rising edges, MSB first
   always @(posedge sck) begin
      if (!cs_n) begin
         in_sr = {in_sr[6:0], mosi};
         moved = 1'h1;
         bitn++;
         if (bitn == 8) begin
            bitn = 0;
            rx_byte = in_sr;
            rx_count++;
         end
      end
   end
   // Shift only after a rising edge, so either idle level works
   always @(negedge sck) begin
      if (!cs_n && moved) begin
         moved = 1'h0;
         out_sr = (bitn == 0) ? 8'h3C + rx_count * 8'h11 : {out_sr[6:0], 1'h0};
      end
   end
   // Released line must not keep showing the last bit
   always @(posedge cs_n) idle_v = ~out_sr[7];
   assign miso = cs_n ? idle_v : out_sr[7];
endmodule : qfc_flash_model

// ==== verif/test_qfc_ctrl.sv ====
`timescale 1ns/100ps
module test_qfc_ctrl;
   import qfc_pkg::*;
   typedef struct {logic [31:0] v; logic [31:0] m; string n;} qfc_note_t;
   logic sys_clk = 1'h0;
   logic rst = 1'h1;
   logic hsel_reg = 1'h0;
   logic hsel_flash = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd_s, v;
   logic [31:0] recv = 32'h0;
   logic hready, rdy_s, cs_n, sck, io0_o, io1_i, io2_i, io2_o, io2_oe, io3_i, io3_o, io3_oe;
   logic rd_dp = 1'h0;
   logic [7:0] rx_byte, rx_count;
   logic [15:0] rnd = 16'h0017;
   int err_count = 0;
   int comparisons = 0;
   int waits;
   qfc_note_t nt;
   qfc_note_t notes[$];

   always #50 sys_clk = ~sys_clk;
   // Pad lines are pulled up when nobody drives them
   assign io2_i = io2_oe ? io2_o : 1'h1;
   assign io3_i = io3_oe ? io3_o : 1'h1;

   qfc_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .hsel_reg(hsel_reg), .hsel_flash(hsel_flash),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready_in(hready),
      .hrdata(hrdata), .hready(hready), .cs_n(cs_n), .sck(sck), .io0_o(io0_o), .io1_i(io1_i),
      .io2_i(io2_i), .io2_o(io2_o), .io2_oe(io2_oe), .io3_i(io3_i), .io3_o(io3_o), .io3_oe(io3_oe));
   qfc_flash_model i_flash (.cs_n(cs_n), .sck(sck), .mosi(io0_o), .miso(io1_i), .rx_byte(rx_byte),
      .rx_count(rx_count));

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr

   function automatic logic [7:0] pb(input int k);
      return 8'h3C + 8'(k) * 8'h11;
   endfunction : pb

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic give_verdict;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict

   // Edge values kept so the driver never races the design's updates
   always @(posedge sys_clk) begin
      rdy_s <= hready;
      rd_s <= hrdata;
   end

   // Completed read data phases are matched against the oldest note
   always @(posedge sys_clk) begin
      if (rd_dp && hready) begin
         if (notes.size() == 0)
            chk("note queue", 32'h1, 32'h0);
         else begin
            nt = notes.pop_front();
            if (nt.m != 32'h0)
               chk(nt.n, nt.v & nt.m, hrdata & nt.m);
         end
      end
      if (hready)
         rd_dp <= !rst && htrans[1] && !hwrite;
   end

   // Bounded wait for an edge with hready high
   task automatic edge_wait(output int n);
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (!rdy_s && n < 1000);
      if (!rdy_s) begin
         chk("hready timeout", 32'h1, 32'h0);
         give_verdict();
      end
   endtask : edge_wait

   // One transfer: address phase held until taken, then data phase
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      hsel_reg = a[31:8] == 24'h0C0000;
      hsel_flash = a[31:8] != 24'h0C0000;
      haddr = a;
      hwrite = wr;
      htrans = 2'h2;
      edge_wait(n);
      hsel_reg = 1'h0;
      hsel_flash = 1'h0;
      htrans = 2'h0;
      hwdata = d;
      edge_wait(waits);
      waits--;
   endtask : bus

   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m, input string n);
      notes.push_back('{e, m, n});
      bus(1'h0, a, 32'h0);
   endtask : rd

   // Software waits on the busy flag when no wait states are used
   task automatic poll;
      int k;
      k = 0;
      do begin
         rd(ADDR_STATUS, 32'h0, 32'h0, "busy");
         k++;
      end while (rd_s[0] !== 1'h0 && k < 200);
      chk("busy clears", 32'h0, {31'h0, rd_s[0]});
   endtask : poll

   // Pad drive and idle clock, given a few cycles to settle
   task automatic pads(input logic [31:0] m);
      repeat (3) @(posedge sys_clk);
      #1;
      chk("io2 pad", {30'h0, m[2], m[2] & m[4]}, {30'h0, io2_oe, io2_oe & io2_o});
      chk("io3 pad", {30'h0, m[3], m[3] & m[5]}, {30'h0, io3_oe, io3_oe & io3_o});
      chk("idle clock", {31'h0, m[1]}, {31'h0, sck});
      // Status shows the pad level: driven value, or the pull-up when released
      rd(ADDR_STATUS, {29'h0, (m[3] ? m[5] : 1'h1), (m[2] ? m[4] : 1'h1), 1'h0}, 32'h6, "pad in");
   endtask : pads

   initial begin
      repeat (20) @(posedge sys_clk);
      #1;
      rst = 1'h0;
      chk("select idle", 32'h1, {31'h0, cs_n});
      rd(ADDR_CTRL_MODE, CTRL_MODE_RST, 32'hFFFF_FFFF, "mode reset");
      rd(ADDR_RECV, RECV_RST, 32'hFFFF_FFFF, "recv reset");
      rd(32'h0C00_0030, 32'h0, 32'hFFFF_FFFF, "unmapped");
      // Random settings in manual mode; reserved bits must read back as zero
      repeat (6) begin
         rnd = lfsr(rnd);
         v = {rnd, rnd} & 32'hFFFF_FFFE;
         bus(1'h1, ADDR_CTRL_MODE, v);
         rd(ADDR_CTRL_MODE, v & CTRL_MODE_MASK, 32'hFFFF_FFFF, "mode rw");
         pads(v);
      end
      // Waited manual transfers in both clock modes
      for (int md = 0; md < 2; md++) begin
         bus(1'h1, ADDR_CTRL_MODE, {30'h0, md[0], 1'h0});
         bus(1'h1, ADDR_CTRL_BUS, 32'h1);
         rnd = lfsr(rnd);
         bus(1'h1, ADDR_WRITE_DATA, {16'h0, rnd});
         chk("write waits", 32'h1, {31'h0, waits > 63});
         chk("byte sent", {24'h0, rnd[7:0]}, {24'h0, rx_byte});
         bus(1'h1, ADDR_DUMMY_DATA, 32'h0);
         chk("dummy byte", 32'hFF, {24'h0, rx_byte});
         // Third byte of the session; a waited read returns the updated word
         recv = {recv[23:0], 8'h5E};
         rd(ADDR_READ_DATA, recv, 32'hFFFF_FFFF, "read port");
         chk("read waits", 32'h1, {31'h0, waits > 63});
         bus(1'h1, ADDR_CTRL_BUS, 32'h2);
         pads({30'h0, md[0], 1'h0});
      end
      rd(ADDR_RECV, recv, 32'hFFFF_FFFF, "recv word");
      // No wait states: accesses return at once and busy is polled
      bus(1'h1, ADDR_CTRL_MODE, 32'h40);
      bus(1'h1, ADDR_CTRL_BUS, 32'h1);
      bus(1'h1, ADDR_WRITE_DATA, 32'hC3);
      chk("nw write", 32'h0, waits);
      // Port access while busy is ignored; the byte seen must stay C3
      bus(1'h1, ADDR_WRITE_DATA, 32'h99);
      poll();
      chk("nw byte", 32'hC3, {24'h0, rx_byte});
      rd(ADDR_READ_DATA, recv, 32'hFFFF_FFFF, "nw read");
      chk("nw read", 32'h0, waits);
      poll();
      recv = {recv[23:0], 8'h4D};
      rd(ADDR_RECV, recv, 32'hFFFF_FFFF, "recv nw");
      bus(1'h1, ADDR_CTRL_BUS, 32'h2);
      // Mode bit locked while erase is enabled, other bits still written
      bus(1'h1, ADDR_ERASE, 32'h1);
      bus(1'h1, ADDR_CTRL_MODE, 32'h43);
      rd(ADDR_CTRL_MODE, 32'h42, 32'hFFFF_FFFF, "mode in erase");
      bus(1'h1, ADDR_ERASE, 32'h0);
      rd(32'h0000_0100, 32'h0, 32'hFFFF_FFFF, "manual flash");
      // Auto reads wait despite no-wait select; pad enables cleared
      for (int aw = 0; aw < 2; aw++) begin
         bus(1'h1, ADDR_CTRL_MODE, {18'h0, aw[0], 13'h0041});
         rd(32'h0012_3456, {pb(7 + aw), pb(6 + aw), pb(5 + aw), pb(4 + aw)}, 32'hFFFF_FFFF, "auto");
         chk("auto waits", 32'h1, {31'h0, waits > 100});
         chk("auto bytes", 8 + aw, {24'h0, rx_count});
      end
      bus(1'h1, ADDR_CTRL_MODE, 32'h0);
      give_verdict();
   end
endmodule : test_qfc_ctrl
